// [core/memory_option_port.sv]
// system-side sequencer for the expansion memory connector
`timescale 1ns/10ps
`default_nettype none
`include "memory_option_port_cfg.svh"
module memory_option_port #(
  parameter int unsigned REFRESH_CYC = `MOP_REFRESH_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        accessReq,
  input  wire logic        accessWrite,
  input  wire logic [19:0] accessAddr,
  input  wire logic [7:0]  accessWrData,
  output logic [7:0]       accessRdData,
  output logic             accessDone,
  input  wire logic        parityTestEnable,
  output logic             parityErrorReport,
  output logic             typeNewer,
  input  wire logic        module_type_sense_n,
  input  wire logic        parity_error_n,
  output logic             access_enable_n,
  output logic             bank1_sel_or_addr16,
  output logic             bank2_sel_or_addr17,
  output logic             bank3_sel_or_addr18,
  output logic             addr19,
  output logic             data_direction,
  output logic             host_read_cycle,
  output logic             host_write_cycle_n,
  output logic             addr_phase_select,
  output logic             row_strobe,
  output logic             column_strobe,
  output logic             refresh_request_n,
  output logic             refresh_row_strobe,
  output logic             refresh_complete,
  output logic             parity_test,
  output logic             init_n,
  output logic [15:0]      memAddr,
  output logic [5:0]       muxAddr,
  input  wire logic [7:0]  buffered_ad_bus_in,
  output logic [7:0]       buffered_ad_bus_out,
  output logic             buffered_ad_bus_oe
);
  import memory_option_port_pkg::*;

  localparam logic [7:0]  ROW_CYC  = 8'(`MOP_ROW_CYC);
  localparam logic [7:0]  MUX_CYC  = 8'(`MOP_MUX_CYC);
  localparam logic [7:0]  CAS_CYC  = 8'(`MOP_CAS_CYC);
  localparam logic [7:0]  PRE_CYC  = 8'(`MOP_PRE_CYC);
  localparam logic [7:0]  RREQ_CYC = 8'(`MOP_RREQ_CYC);
  localparam logic [7:0]  RRAS_CYC = 8'(`MOP_RRAS_CYC);
  localparam logic [15:0] INIT_CYC = 16'(`MOP_INIT_CYC);

  // active-low select for one of the three 64K banks
  function automatic logic bankSelN(input logic [3:0] bank, input logic [3:0] idx);
    bankSelN = (bank != idx);
  endfunction

  refresh_link_if rfsh ();

  refresh_scheduler #(
    .INTERVAL_CYC (REFRESH_CYC)
  ) u_sched (
    .clock  (clock),
    .arst_n (arst_n),
    .link   (rfsh)
  );

  portState_t  state_q;
  portState_t  state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic [15:0] initCnt_q;
  logic [15:0] initCnt_d;
  logic [19:0] addr_q;
  logic [19:0] addr_d;
  logic        wr_q;
  logic        wr_d;
  logic [7:0]  wrData_q;
  logic [7:0]  wrData_d;
  logic [7:0]  rdData_d;
  logic        done_d;
  logic        newer_d;
  logic        inAccess;
  logic        strobeRow;
  logic        strobeMux;
  logic        strobeCol;

  assign rfsh.ack = (state_q == S_RDON);

  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    addr_d    = addr_q;
    wr_d      = wr_q;
    wrData_d  = wrData_q;
    rdData_d  = accessRdData;
    done_d    = 1'b0;
    newer_d   = typeNewer;
    initCnt_d = (initCnt_q != 16'h0000) ? initCnt_q - 16'h0001 : 16'h0000;
    if (cnt_q != 8'h00)
    begin
      cnt_d = cnt_q - 8'h01;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          // type sense only sampled between cycles so pins never change mid-access
          newer_d = module_type_sense_n;
          if (initCnt_q != 16'h0000)
          begin
            state_d = S_IDLE;
          end
          else if (rfsh.pending)
          begin
            state_d = S_RREQ;
            cnt_d   = RREQ_CYC - 8'h01;
          end
          else if (accessReq && !accessDone)
          begin
            addr_d   = accessAddr;
            wr_d     = accessWrite;
            wrData_d = accessWrData;
            state_d  = S_ROW;
            cnt_d    = ROW_CYC - 8'h01;
          end
        end
        S_ROW:
        begin
          state_d = S_MUX;
          cnt_d   = MUX_CYC - 8'h01;
        end
        S_MUX:
        begin
          state_d = S_COL;
          cnt_d   = CAS_CYC - 8'h01;
        end
        S_COL:
        begin
          if (!wr_q)
          begin
            rdData_d = buffered_ad_bus_in;
          end
          state_d = S_PRE;
          cnt_d   = PRE_CYC - 8'h01;
        end
        S_PRE:
        begin
          state_d = S_IDLE;
          done_d  = 1'b1;
        end
        S_RREQ:
        begin
          state_d = S_RRAS;
          cnt_d   = RRAS_CYC - 8'h01;
        end
        S_RRAS:
        begin
          state_d = S_RDON;
        end
        S_RDON:
        begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    // strobes end before precharge so the next cycle starts clean
    inAccess  = (state_d == S_ROW) || (state_d == S_MUX) || (state_d == S_COL);
    strobeRow = inAccess;
    strobeMux = (state_d == S_MUX) || (state_d == S_COL);
    strobeCol = (state_d == S_COL);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q             <= S_IDLE;
      cnt_q               <= 8'h00;
      initCnt_q           <= INIT_CYC;
      addr_q              <= 20'h00000;
      wr_q                <= 1'b0;
      wrData_q            <= 8'h00;
      accessRdData        <= 8'h00;
      accessDone          <= 1'b0;
      typeNewer           <= 1'b0;
      parityErrorReport   <= 1'b0;
      parity_test         <= 1'b0;
      init_n              <= 1'b0;
      access_enable_n     <= 1'b1;
      bank1_sel_or_addr16 <= 1'b1;
      bank2_sel_or_addr17 <= 1'b1;
      bank3_sel_or_addr18 <= 1'b1;
      addr19              <= 1'b0;
      data_direction      <= 1'b1;
      host_read_cycle     <= 1'b0;
      host_write_cycle_n  <= 1'b1;
      addr_phase_select   <= 1'b0;
      row_strobe          <= 1'b0;
      column_strobe       <= 1'b0;
      refresh_request_n   <= 1'b1;
      refresh_row_strobe  <= 1'b0;
      refresh_complete    <= 1'b0;
      memAddr             <= 16'h0000;
      muxAddr             <= 6'h00;
      buffered_ad_bus_out <= 8'h00;
      buffered_ad_bus_oe  <= 1'b0;
    end
    else
    begin
      state_q             <= state_d;
      cnt_q               <= cnt_d;
      initCnt_q           <= initCnt_d;
      addr_q              <= addr_d;
      wr_q                <= wr_d;
      wrData_q            <= wrData_d;
      accessRdData        <= rdData_d;
      accessDone          <= done_d;
      typeNewer           <= newer_d;
      parityErrorReport   <= ~parity_error_n;
      parity_test         <= parityTestEnable;
      init_n              <= (initCnt_d == 16'h0000);
      access_enable_n     <= ~inAccess;
      if (newer_d)
      begin
        bank1_sel_or_addr16 <= addr_d[`MOP_BANK_LSB];
        bank2_sel_or_addr17 <= addr_d[`MOP_BANK_LSB + 1];
        bank3_sel_or_addr18 <= addr_d[`MOP_BANK_LSB + 2];
      end
      else
      begin
        bank1_sel_or_addr16 <= ~inAccess | bankSelN(addr_d[`MOP_BANK_MSB:`MOP_BANK_LSB], 4'h1);
        bank2_sel_or_addr17 <= ~inAccess | bankSelN(addr_d[`MOP_BANK_MSB:`MOP_BANK_LSB], 4'h2);
        bank3_sel_or_addr18 <= ~inAccess | bankSelN(addr_d[`MOP_BANK_MSB:`MOP_BANK_LSB], 4'h3);
      end
      addr19              <= addr_d[`MOP_ADDR19_BIT];
      data_direction      <= ~(inAccess & wr_d);
      host_read_cycle     <= inAccess & ~wr_d;
      host_write_cycle_n  <= ~(inAccess & wr_d);
      addr_phase_select   <= strobeMux;
      row_strobe          <= strobeRow;
      column_strobe       <= strobeCol;
      refresh_request_n   <= ~((state_d == S_RREQ) || (state_d == S_RRAS));
      refresh_row_strobe  <= (state_d == S_RRAS);
      refresh_complete    <= (state_d == S_RDON);
      memAddr             <= addr_d[15:0];
      muxAddr             <= strobeMux ? addr_d[`MOP_MUX_HI_MSB:`MOP_MUX_HI_LSB]
                                       : addr_d[`MOP_MUX_LO_MSB:`MOP_MUX_LO_LSB];
      buffered_ad_bus_out <= wrData_d;
      buffered_ad_bus_oe  <= inAccess & wr_d;
    end
  end
endmodule
`default_nettype wire

// [core/memory_option_port_cfg.svh]
// timing and reset constants for the memory option port
`ifndef MEMORY_OPTION_PORT_CFG_SVH
`define MEMORY_OPTION_PORT_CFG_SVH

`define MOP_CLK_NS          10
`define MOP_T_ROW_NS        30
`define MOP_T_MUX_NS        20
`define MOP_T_CAS_NS        60
`define MOP_T_PRE_NS        40
`define MOP_T_RREQ_NS       20
`define MOP_T_RRAS_NS       80
`define MOP_T_INIT_NS       1000
`define MOP_T_REFRESH_NS    15600

// least times round up, the refresh interval (a longest time) rounds down
`define MOP_CEIL_CYC(ns)    (((ns) + `MOP_CLK_NS - 1) / `MOP_CLK_NS)
`define MOP_ROW_CYC         `MOP_CEIL_CYC(`MOP_T_ROW_NS)
`define MOP_MUX_CYC         `MOP_CEIL_CYC(`MOP_T_MUX_NS)
`define MOP_CAS_CYC         `MOP_CEIL_CYC(`MOP_T_CAS_NS)
`define MOP_PRE_CYC         `MOP_CEIL_CYC(`MOP_T_PRE_NS)
`define MOP_RREQ_CYC        `MOP_CEIL_CYC(`MOP_T_RREQ_NS)
`define MOP_RRAS_CYC        `MOP_CEIL_CYC(`MOP_T_RRAS_NS)
`define MOP_INIT_CYC        `MOP_CEIL_CYC(`MOP_T_INIT_NS)
`define MOP_REFRESH_CYC     (`MOP_T_REFRESH_NS / `MOP_CLK_NS)

// field positions of the processor address
`define MOP_BANK_MSB        19
`define MOP_BANK_LSB        16
`define MOP_ADDR19_BIT      19
`define MOP_MUX_HI_MSB      15
`define MOP_MUX_HI_LSB      10
`define MOP_MUX_LO_MSB      5
`define MOP_MUX_LO_LSB      0

`endif

// [core/memory_option_port_pkg.sv]
// types shared by the memory option port
`default_nettype none
package memory_option_port_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ROW  = 3'b001,
    S_MUX  = 3'b010,
    S_COL  = 3'b011,
    S_PRE  = 3'b100,
    S_RREQ = 3'b101,
    S_RRAS = 3'b110,
    S_RDON = 3'b111
  } portState_t;
endpackage
`default_nettype wire

// [core/refresh_link_if.sv]
// refresh request handshake between scheduler and port sequencer
`timescale 1ns/10ps
`default_nettype none
interface refresh_link_if;
  logic pending;
  logic ack;
  modport scheduler (output pending, input ack);
  modport sequencer (input pending, output ack);
endinterface
`default_nettype wire

// [core/refresh_scheduler.sv]
// periodic refresh request generator
`timescale 1ns/10ps
`default_nettype none
`include "memory_option_port_cfg.svh"
module refresh_scheduler #(
  parameter int unsigned INTERVAL_CYC = `MOP_REFRESH_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  refresh_link_if.scheduler link
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        pend_q;
  logic        pend_d;
  logic        tick;

  always_comb
  begin
    tick   = (cnt_q == 16'h0000);
    cnt_d  = tick ? 16'(INTERVAL_CYC - 1) : cnt_q - 16'h0001;
    // a new tick wins over the acknowledge of the previous refresh
    pend_d = tick ? 1'b1 : (pend_q & ~link.ack);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q  <= 16'h0000;
      pend_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      pend_q <= pend_d;
    end
  end

  assign link.pending = pend_q;
endmodule
`default_nettype wire

// [tb/mop_monitor.sv]
// concurrent checks on the memory option port pins
`timescale 1ns/10ps
`default_nettype none
module mop_monitor (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        row_strobe,
  input wire logic        column_strobe,
  input wire logic        addr_phase_select,
  input wire logic [5:0]  muxAddr,
  input wire logic [15:0] memAddr,
  input wire logic        host_write_cycle_n,
  input wire logic        host_read_cycle,
  input wire logic        data_direction,
  input wire logic        buffered_ad_bus_oe,
  input wire logic        access_enable_n,
  input wire logic        refresh_request_n,
  input wire logic        refresh_row_strobe,
  input wire logic        refresh_complete,
  input wire logic        parity_error_n,
  input wire logic        parityErrorReport,
  input wire logic        parityTestEnable,
  input wire logic        parity_test,
  input wire logic        typeNewer,
  input wire logic        bank1_sel_or_addr16,
  input wire logic        bank2_sel_or_addr17,
  input wire logic        bank3_sel_or_addr18
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_strobe_order: assert property ($rose(row_strobe) |-> ##3 (addr_phase_select &&
    !column_strobe) ##2 column_strobe) else $error("strobe order wrong");
  a_column_len: assert property ($rose(column_strobe) |-> column_strobe[*6] ##1
    (!column_strobe && !row_strobe)) else $error("column phase length wrong");
  a_mux_high: assert property (addr_phase_select |-> muxAddr == memAddr[15:10])
    else $error("high address not on mux lines");
  a_mux_low: assert property (row_strobe && !addr_phase_select |->
    muxAddr == memAddr[5:0]) else $error("low address not on mux lines");
  a_write_dir: assert property (!host_write_cycle_n |-> !data_direction &&
    buffered_ad_bus_oe && !access_enable_n) else $error("write cycle pins wrong");
  a_read_dir: assert property (host_read_cycle |-> data_direction &&
    !buffered_ad_bus_oe && !access_enable_n) else $error("read cycle pins wrong");
  a_refresh_seq: assert property ($fell(refresh_request_n) |-> ##2
    refresh_row_strobe[*8] ##1 (refresh_complete && refresh_request_n))
    else $error("refresh sequence wrong");
  a_bank_onehot: assert property (!typeNewer && !access_enable_n |->
    $onehot0(~{bank3_sel_or_addr18, bank2_sel_or_addr17, bank1_sel_or_addr16}))
    else $error("more than one bank selected");
  a_parity_pass: assert property (parityErrorReport == !$past(parity_error_n))
    else $error("parity error not passed on");
  a_parity_test: assert property (parity_test == $past(parityTestEnable))
    else $error("parity test output wrong");
  c_write: cover property (!host_write_cycle_n);
  c_read: cover property (host_read_cycle);
  c_refresh: cover property (refresh_complete);
  c_newer: cover property (typeNewer && !access_enable_n);
endmodule
bind memory_option_port mop_monitor mop_monitor_i (.clock, .arst_n, .row_strobe,
  .column_strobe, .addr_phase_select, .muxAddr, .memAddr, .host_write_cycle_n,
  .host_read_cycle, .data_direction, .buffered_ad_bus_oe, .access_enable_n,
  .refresh_request_n, .refresh_row_strobe, .refresh_complete, .parity_error_n,
  .parityErrorReport, .parityTestEnable, .parity_test, .typeNewer,
  .bank1_sel_or_addr16, .bank2_sel_or_addr17, .bank3_sel_or_addr18);
`default_nettype wire

// [tb/mem_module_model.sv]
// behavioural expansion memory module on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module mem_module_model (
  input  wire logic        clock,
  input  wire logic        init_n,
  input  wire logic        newerType,
  input  wire logic        column_strobe,
  input  wire logic        host_read_cycle,
  input  wire logic        host_write_cycle_n,
  input  wire logic        parity_test,
  input  wire logic [15:0] memAddr,
  input  wire logic [7:0]  buffered_ad_bus_out,
  input  wire logic        buffered_ad_bus_oe,
  output logic             module_type_sense_n,
  output logic             parity_error_n,
  output logic [7:0]       buffered_ad_bus_in
);
  logic [7:0] store [256];
  logic [7:0] lastQ;
  assign module_type_sense_n = newerType;
  // parity test makes the checker report an error
  assign parity_error_n = ~parity_test;
  // off the bus the lines toggle so a stale value never matches
  assign buffered_ad_bus_in = (column_strobe && host_read_cycle) ?
    store[memAddr[7:0]] : ~lastQ;
  always @(posedge clock or negedge init_n)
  begin
    if (!init_n)
      lastQ <= 8'h00;
    else
    begin
      lastQ <= buffered_ad_bus_in;
      if (column_strobe && !host_write_cycle_n && buffered_ad_bus_oe)
        store[memAddr[7:0]] <= buffered_ad_bus_out;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the memory option port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, arst_n = 1'b0, accessReq = 1'b0, accessWrite = 1'b0;
  logic [19:0] accessAddr = 20'h0;
  logic [7:0] accessWrData = 8'h0, accessRdData, buffered_ad_bus_in, buffered_ad_bus_out;
  logic parityTestEnable = 1'b0, newerType = 1'b0, accessDone, parityErrorReport, typeNewer;
  logic module_type_sense_n, parity_error_n, access_enable_n, addr19, data_direction;
  logic bank1_sel_or_addr16, bank2_sel_or_addr17, bank3_sel_or_addr18, host_read_cycle;
  logic host_write_cycle_n, addr_phase_select, row_strobe, column_strobe, refresh_request_n;
  logic refresh_row_strobe, refresh_complete, parity_test, init_n, buffered_ad_bus_oe;
  logic [15:0] memAddr;
  logic [5:0] muxAddr;
  int nMismatch = 0, totalChecks = 0;
  always #5 clock = ~clock;
  memory_option_port #(.REFRESH_CYC(40)) memory_option_port_i (.clock, .arst_n, .accessReq,
    .accessWrite, .accessAddr, .accessWrData, .accessRdData, .accessDone, .parityTestEnable,
    .parityErrorReport, .typeNewer, .module_type_sense_n, .parity_error_n, .access_enable_n,
    .bank1_sel_or_addr16, .bank2_sel_or_addr17, .bank3_sel_or_addr18, .addr19,
    .data_direction, .host_read_cycle, .host_write_cycle_n, .addr_phase_select, .row_strobe,
    .column_strobe, .refresh_request_n, .refresh_row_strobe, .refresh_complete, .parity_test,
    .init_n, .memAddr, .muxAddr, .buffered_ad_bus_in, .buffered_ad_bus_out,
    .buffered_ad_bus_oe);
  mem_module_model mem_module_model_i (.clock, .init_n, .newerType, .column_strobe,
    .host_read_cycle, .host_write_cycle_n, .parity_test, .memAddr, .buffered_ad_bus_out,
    .buffered_ad_bus_oe, .module_type_sense_n, .parity_error_n, .buffered_ad_bus_in);
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic completeRun();
    $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bank pins captured while the access is enabled
  task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] d,
                        output logic [2:0] bk);
    int n;
    n = 0;
    bk = 3'h7;
    @(posedge clock);
    accessReq <= 1'b1;
    accessWrite <= wr;
    accessAddr <= a;
    accessWrData <= d;
    do
    begin
      @(negedge clock);
      n++;
      if (access_enable_n === 1'b0)
        bk = {bank3_sel_or_addr18, bank2_sel_or_addr17, bank1_sel_or_addr16};
    end while (accessDone !== 1'b1 && n < 200);
    chk(accessDone, 1'b1);
    @(posedge clock);
    accessReq <= 1'b0;
  endtask
  task automatic t_init();
    int n;
    n = 0;
    @(negedge clock);
    chk(init_n, 1'b0);
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    while (init_n === 1'b0 && n < 300)
    begin
      n++;
      @(negedge clock);
    end
    chk(20'(n), 20'd100);
  endtask
  task automatic t_refresh();
    int n;
    n = 0;
    while (refresh_complete !== 1'b1 && n < 100)
    begin
      n++;
      @(negedge clock);
    end
    chk(refresh_complete, 1'b1);
    chk({refresh_request_n, refresh_row_strobe}, 2'h2);
  endtask
  // a base address, each of the three banks and bank 4, which selects none, then read back
  task automatic t_older();
    logic [2:0] bk;
    chk(typeNewer, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      access(1'b1, {i[3:0], 8'h3C, i[7:0]}, 8'hA0 + i[7:0], bk);
      chk(bk, (i >= 1 && i <= 3) ? 3'h7 ^ (3'h1 << (i - 1)) : 3'h7);
    end
    for (int i = 0; i < 5; i++)
    begin
      access(1'b0, {i[3:0], 8'h3C, i[7:0]}, 8'h00, bk);
      chk(accessRdData, 8'hA0 + i[7:0]);
    end
  endtask
  task automatic t_newer();
    logic [2:0] bk;
    logic [19:0] av [3] = '{20'hD5A11, 20'h6C312, 20'hB0013};
    @(posedge clock);
    newerType <= 1'b1;
    repeat (20) @(negedge clock);
    chk(typeNewer, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      access(1'b1, av[i], 8'h5A ^ av[i][7:0], bk);
      chk(bk, av[i][18:16]);
      chk(addr19, av[i][19]);
      access(1'b0, av[i], 8'h00, bk);
      chk(accessRdData, 8'h5A ^ av[i][7:0]);
    end
  endtask
  task automatic t_parity();
    @(posedge clock);
    parityTestEnable <= 1'b1;
    repeat (3) @(negedge clock);
    chk(parity_test, 1'b1);
    chk(parityErrorReport, 1'b1);
    @(posedge clock);
    parityTestEnable <= 1'b0;
    repeat (3) @(negedge clock);
    chk(parityErrorReport, 1'b0);
  endtask
  initial
  begin
    t_init();
    t_refresh();
    t_older();
    t_newer();
    t_parity();
    completeRun();
  end
  // the whole sequence needs well under 5000 cycles
  initial
  begin
    #100000;
    nMismatch++;
    completeRun();
  end
endmodule
`default_nettype wire
